/* File: src/oau_map.vh */
// constants for the operand addressing unit
`ifndef OAU_MAP_VH
`define OAU_MAP_VH
`define OAU_AS_REG 2'h0
`define OAU_AS_IDX 2'h1
`define OAU_AS_IND 2'h2
`define OAU_AS_INC 2'h3
`define OAU_AD_REG 1'h0
`define OAU_AD_IDX 1'h1
`define OAU_PC_NUM 4'h0
`define OAU_SP_NUM 4'h1
`define OAU_SW_NUM 4'h2
`define OAU_CG_NUM 4'h3
`define OAU_GR_LO 4'h4
`define OAU_INC_BYTE 16'h0001
`define OAU_INC_WORD 16'h0002
`define OAU_CG_4 16'h0004
`define OAU_CG_8 16'h0008
`define OAU_CG_0 16'h0000
`define OAU_CG_1 16'h0001
`define OAU_CG_2 16'h0002
`define OAU_CG_ONES 16'hffff
`define OAU_GR_RST 16'h0000
`define OAU_PC_RST 16'h0000
`endif

/* File: src/oau_regfile.v */
// twelve general registers with byte and word writes
`timescale 1ns/1ps
`include "oau_map.vh"
module oau_regfile #(
   parameter NREG = 12
) (
   input wire clk, // core clock
   input wire rst_n, // synchronised reset, active low
   input wire ce, // clock enable
   input wire [3:0] ra_num, // read port a register number
   input wire [3:0] rb_num, // read port b register number
   output wire [15:0] ra_data, // read port a data
   output wire [15:0] rb_data, // read port b data
   input wire w1_en, // result write enable
   input wire [3:0] w1_num, // result register number
   input wire [15:0] w1_data, // result data
   input wire w1_byte, // byte-size result
   input wire w2_en, // pointer update enable
   input wire [3:0] w2_num, // pointer register number
   input wire [15:0] w2_data // new pointer value
);
   reg [15:0] general_registers_r [0:NREG-1];
   // numbers below four are not general registers and read as zero
   function [15:0] rd;
      input [3:0] n;
      begin
         if (n >= `OAU_GR_LO)
            rd = general_registers_r[n - `OAU_GR_LO];
         else
            rd = 16'h0000;
      end
   endfunction
   assign ra_data = rd(ra_num);
   assign rb_data = rd(rb_num);
   genvar g;
   generate
      for (g = 0; g < NREG; g = g + 1)
      begin : gr
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               general_registers_r[g] <= `OAU_GR_RST;
            else if (ce && w1_en && w1_num == g + `OAU_GR_LO)
               general_registers_r[g] <= w1_byte ? {8'h00, w1_data[7:0]} : w1_data;
            else if (ce && w2_en && w2_num == g + `OAU_GR_LO)
               general_registers_r[g] <= w2_data;
         end
      end
   endgenerate
endmodule // oau_regfile

/* File: src/oau_srcgen.v */
// source operand mode decode and constant generation
`timescale 1ns/1ps
`include "oau_map.vh"
module oau_srcgen (
   input wire [3:0] src_num, // source register number
   input wire [1:0] source_mode_field, // source mode bits
   output reg cg_hit, // constant substitutes the operand
   output reg [15:0] cg_val, // constant value
   output reg abs_base // base reads as zero
);
   always @*
   begin
      cg_hit = 1'b0;
      cg_val = `OAU_CG_0;
      abs_base = 1'b0;
      if (src_num == `OAU_SW_NUM)
      begin
         case (source_mode_field)
            `OAU_AS_IDX: abs_base = 1'b1;
            `OAU_AS_IND:
            begin
               cg_hit = 1'b1;
               cg_val = `OAU_CG_4;
            end
            `OAU_AS_INC:
            begin
               cg_hit = 1'b1;
               cg_val = `OAU_CG_8;
            end
            default: cg_hit = 1'b0;
         endcase
      end
      else if (src_num == `OAU_CG_NUM)
      begin
         cg_hit = 1'b1;
         case (source_mode_field)
            `OAU_AS_REG: cg_val = `OAU_CG_0;
            `OAU_AS_IDX: cg_val = `OAU_CG_1;
            `OAU_AS_IND: cg_val = `OAU_CG_2;
            default: cg_val = `OAU_CG_ONES;
         endcase
      end
   end
endmodule // oau_srcgen

/* File: src/oau_top.v */
// operand addressing unit: mode decode, address forming, operand fetch
`timescale 1ns/1ps
`include "oau_map.vh"
module oau_top (
   input wire sys_clk, // core clock
   input wire rstn, // async reset, active low
   input wire clk_en, // freezes all state but the reset release while low
   input wire op_start, // pulse: begin an operand sequence
   input wire [3:0] src_num, // source register number
   input wire [1:0] source_mode_field, // source mode
   input wire [3:0] dst_num, // destination register number
   input wire dst_mode, // destination mode
   input wire byte_op, // byte-size instruction
   input wire [15:0] pc_in, // program counter at the word after opcode
   input wire [15:0] sp_in, // stack pointer value
   input wire [15:0] status_word_register, // status word value
   input wire res_valid, // pulse: result ready from alu
   input wire [15:0] res_data, // alu result
   input wire mem_ack, // memory answers this cycle
   input wire [15:0] mem_rdata, // memory read data
   output reg mem_req, // memory read request
   output reg [15:0] mem_addr, // memory address
   output reg src_valid, // pulse: source and dest operands ready
   output reg [15:0] src_op, // source operand
   output reg [15:0] dst_op, // destination operand
   output reg dst_is_mem, // destination lives in memory
   output reg [15:0] dst_addr, // destination address
   output reg [15:0] pc_out, // program counter after extension words
   output reg [3:0] flags_nzc, // n,z flags, c bit held at zero, and byte marker
   output reg busy // sequence in progress
);
   ////////////////////////////////////////////////////////////////
   // reset release
   reg rst_m_r;
   reg rst_s_r;
   always @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         rst_m_r <= 1'b0;
         rst_s_r <= 1'b0;
      end
      else
      begin
         rst_m_r <= 1'b1;
         rst_s_r <= rst_m_r;
      end
   end
   ////////////////////////////////////////////////////////////////
   // states
   localparam ST_IDLE = 3'h0;
   localparam ST_SEXT = 3'h1;
   localparam ST_SRD = 3'h2;
   localparam ST_DEXT = 3'h3;
   localparam ST_DRD = 3'h4;
   localparam ST_DONE = 3'h5;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [3:0] sn_r;
   reg [1:0] sm_r;
   reg [3:0] dn_r;
   reg dm_r;
   reg byte_r;
   wire [15:0] ra_data;
   wire [15:0] rb_data;
   wire cg_hit;
   wire [15:0] cg_val;
   wire abs_base;
   reg w1_en;
   reg w2_en;
   reg [15:0] w2_data;
   // register values including pc and sp, decoded twice so a function
   function [15:0] regval;
      input [3:0] n;
      input [15:0] gr;
      input [15:0] pc;
      begin
         case (n)
            `OAU_PC_NUM: regval = pc;
            `OAU_SP_NUM: regval = sp_in;
            `OAU_SW_NUM: regval = status_word_register;
            `OAU_CG_NUM: regval = 16'h0000;
            default: regval = gr;
         endcase
      end
   endfunction
   oau_regfile #(
      .NREG(12)
   ) u_rf (
      .clk(sys_clk),
      .rst_n(rst_s_r),
      .ce(clk_en),
      .ra_num(sn_r),
      .rb_num(dn_r),
      .ra_data(ra_data),
      .rb_data(rb_data),
      .w1_en(w1_en),
      .w1_num(dn_r),
      .w1_data(res_data),
      .w1_byte(byte_r),
      .w2_en(w2_en),
      .w2_num(sn_r),
      .w2_data(w2_data)
   );
   oau_srcgen u_cg (
      .src_num(sn_r),
      .source_mode_field(sm_r),
      .cg_hit(cg_hit),
      .cg_val(cg_val),
      .abs_base(abs_base)
   );
   ////////////////////////////////////////////////////////////////
   // operand values and addresses
   wire [15:0] src_reg = regval(sn_r, ra_data, pc_out);
   wire [15:0] dst_reg = regval(dn_r, rb_data, pc_out);
   wire [15:0] src_base = abs_base ? 16'h0000 : src_reg;
   wire [15:0] step = byte_r ? `OAU_INC_BYTE : `OAU_INC_WORD;
   // byte operands never carry a stale high byte to the alu
   wire [15:0] size_mask = byte_r ? 16'h00ff : 16'hffff;
   wire src_imm = (sn_r == `OAU_PC_NUM) && (sm_r == `OAU_AS_INC);
   wire src_ext = !cg_hit && (sm_r == `OAU_AS_IDX);
   wire src_mem = !cg_hit && (sm_r != `OAU_AS_REG);
   wire dst_mem_w = (dm_r == `OAU_AD_IDX);
   wire [7:0] res_lo = res_data[7:0];
   wire res_n = byte_r ? res_lo[7] : res_data[15];
   wire res_z = byte_r ? (res_lo == 8'h00) : (res_data == 16'h0000);
   ////////////////////////////////////////////////////////////////
   // next state
   // independent mode pairing
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
            if (op_start)
               state_nxt = ST_SEXT;
         ST_SEXT:
            if (!src_ext || mem_ack)
               state_nxt = src_mem ? ST_SRD : ST_DEXT;
         ST_SRD:
            if (mem_ack)
               state_nxt = ST_DEXT;
         ST_DEXT:
            if (!dst_mem_w || mem_ack)
               state_nxt = dst_mem_w ? ST_DRD : ST_DONE;
         ST_DRD:
            if (mem_ack)
               state_nxt = ST_DONE;
         ST_DONE:
            if (res_valid)
               state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end
   // writes back to the register file
   always @*
   begin
      w1_en = clk_en && (state_r == ST_DONE) && res_valid && !dst_is_mem
         && (dn_r >= `OAU_GR_LO);
      w2_en = clk_en && (state_r == ST_SRD) && mem_ack && !cg_hit
         && (sm_r == `OAU_AS_INC) && (sn_r >= `OAU_GR_LO);
      w2_data = src_reg + step;
   end
   ////////////////////////////////////////////////////////////////
   // sequence registers
   always @(posedge sys_clk or negedge rst_s_r)
   begin
      if (!rst_s_r)
      begin
         state_r <= ST_IDLE;
         sn_r <= 4'h0;
         sm_r <= 2'h0;
         dn_r <= 4'h0;
         dm_r <= 1'b0;
         byte_r <= 1'b0;
         mem_req <= 1'b0;
         mem_addr <= 16'h0000;
         src_valid <= 1'b0;
         src_op <= 16'h0000;
         dst_op <= 16'h0000;
         dst_is_mem <= 1'b0;
         dst_addr <= 16'h0000;
         pc_out <= `OAU_PC_RST;
         flags_nzc <= 4'h0;
         busy <= 1'b0;
      end
      else if (clk_en)
      begin
         state_r <= state_nxt;
         src_valid <= 1'b0;
         mem_req <= 1'b0;
         case (state_r)
            ST_IDLE:
               if (op_start)
               begin
                  sn_r <= src_num;
                  sm_r <= source_mode_field;
                  dn_r <= dst_num;
                  dm_r <= dst_mode;
                  byte_r <= byte_op;
                  pc_out <= pc_in;
                  busy <= 1'b1;
               end
            ST_SEXT:
               if (src_ext && !mem_ack)
               begin
                  mem_req <= 1'b1;
                  mem_addr <= pc_out;
               end
               else
               begin
                  if (src_ext)
                  begin
                     pc_out <= pc_out + 16'h0002;
                     mem_addr <= src_base + mem_rdata;
                  end
                  else
                     mem_addr <= src_imm ? pc_out : src_reg;
                  mem_req <= src_mem;
                  // register or constant, low byte only for byte ops
                  if (cg_hit)
                     src_op <= cg_val & size_mask;
                  else
                     src_op <= src_reg & size_mask;
               end
            ST_SRD:
               if (mem_ack)
               begin
                  src_op <= byte_r ? {8'h00, mem_rdata[7:0]} : mem_rdata;
                  if (src_imm)
                     pc_out <= pc_out + 16'h0002;
               end
               else
                  mem_req <= 1'b1;
            ST_DEXT:
               if (dst_mem_w && !mem_ack)
               begin
                  mem_req <= 1'b1;
                  mem_addr <= pc_out;
               end
               else if (dst_mem_w)
               begin
                  pc_out <= pc_out + 16'h0002;
                  dst_addr <= ((dn_r == `OAU_SW_NUM) ? 16'h0000 : dst_reg) + mem_rdata;
                  mem_addr <= ((dn_r == `OAU_SW_NUM) ? 16'h0000 : dst_reg) + mem_rdata;
                  mem_req <= 1'b1;
                  dst_is_mem <= 1'b1;
               end
               else
               begin
                  dst_is_mem <= 1'b0;
                  dst_op <= byte_r ? {8'h00, dst_reg[7:0]} : dst_reg;
                  src_valid <= 1'b1;
               end
            ST_DRD:
               if (mem_ack)
               begin
                  dst_op <= byte_r ? {8'h00, mem_rdata[7:0]} : mem_rdata;
                  src_valid <= 1'b1;
               end
               else
                  mem_req <= 1'b1;
            ST_DONE:
               if (res_valid)
               begin
                  flags_nzc <= {res_n, res_z, 1'b0, byte_r};
                  busy <= 1'b0;
               end
            default: busy <= 1'b0;
         endcase
      end
   end
endmodule // oau_top

/* File: sim/oau_asserts.sv */
// port checker for the operand addressing unit
`timescale 1ns/1ps
module oau_asserts (
   input wire sys_clk, // core clock
   input wire rstn, // reset, active low
   input wire clk_en, // run enable
   input wire op_start, // start pulse
   input wire [3:0] src_num, // source register
   input wire [1:0] source_mode_field, // source mode
   input wire dst_mode, // destination mode
   input wire byte_op, // byte size
   input wire [15:0] pc_in, // pc at start
   input wire res_valid, // result pulse
   input wire [15:0] res_data, // result
   input wire mem_ack, // memory answer
   input wire mem_req, // memory request
   input wire [15:0] mem_addr, // memory address
   input wire src_valid, // operands ready
   input wire [15:0] src_op, // source operand
   input wire [15:0] dst_op, // destination operand
   input wire [15:0] pc_out, // advanced pc
   input wire [3:0] flags_nzc, // flags
   input wire busy // in progress
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   reg [3:0] sn_r;
   reg [1:0] sm_r;
   reg dm_r, by_r, dn_r;
   reg [15:0] pc_r, res_r;
   // decode of the fields latched at the accepted start
   wire go = op_start && !busy && clk_en;
   wire cg = sn_r == 4'h3 || (sn_r == 4'h2 && sm_r[1]);
   wire ext = (sm_r == 2'h1 && !cg) || (sn_r == 4'h0 && sm_r == 2'h3);
   wire [15:0] nx = {14'h0, ext, 1'b0} + {14'h0, dm_r, 1'b0};
   wire [15:0] cv = sn_r == 4'h2 ? (sm_r[0] ? 16'h0008 : 16'h0004) : sm_r == 2'h0 ? 16'h0000 :
      sm_r == 2'h1 ? 16'h0001 : sm_r == 2'h2 ? 16'h0002 : 16'hffff;
   wire [15:0] mk = by_r ? 16'h00ff : 16'hffff;
   // operands shown: the result may be taken at the very edge that ends the ready pulse
   wire rdy = dn_r || src_valid;
   ////////////////////////////////////////////////////////////////////////////////
   // no reset here: every use is gated by busy or src_valid, so stale fields are harmless
   always @(posedge sys_clk)
   begin
      res_r <= res_data;
      dn_r <= go ? 1'b0 : (dn_r | src_valid);
      if (go)
         {sn_r, sm_r, dm_r, by_r, pc_r} <= {src_num, source_mode_field, dst_mode, byte_op, pc_in};
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_start_busy: assert property (go |=> busy)
      else $error("start not taken");
   a_valid_pulse: assert property (src_valid && clk_en |=> !src_valid)
      else $error("operand ready held too long");
   a_byte_high: assert property (src_valid && by_r |->
      src_op[15:8] == 8'h00 && dst_op[15:8] == 8'h00)
      else $error("byte operand high byte set");
   a_const_value: assert property (src_valid && cg |-> src_op == (cv & mk))
      else $error("constant source wrong");
   a_reg_nofetch: assert property (busy && sm_r == 2'h0 && !dm_r |-> !mem_req)
      else $error("register mode fetched memory");
   a_ext_count: assert property (src_valid |-> pc_out == pc_r + nx)
      else $error("pc not advanced per extension word");
   a_req_hold: assert property (mem_req && !mem_ack && clk_en |=>
      mem_req && $stable(mem_addr))
      else $error("request dropped before answer");
   a_done_release: assert property (rdy && busy && res_valid && clk_en |=> !busy)
      else $error("result not taken");
   a_byte_flags: assert property (rdy && busy && res_valid && by_r && clk_en |=>
      flags_nzc == {res_r[7], res_r[7:0] == 8'h00, 2'b01})
      else $error("byte flags wrong");
endmodule // oau_asserts

bind oau_top oau_asserts u_oau_chk (.sys_clk, .rstn, .clk_en, .op_start, .src_num,
   .source_mode_field, .dst_mode, .byte_op, .pc_in, .res_valid, .res_data, .mem_ack, .mem_req,
   .mem_addr, .src_valid, .src_op, .dst_op, .pc_out, .flags_nzc, .busy);

/* File: sim/oau_mem_model.sv */
// memory partner answering operand and extension word reads
`timescale 1ns/1ps
module oau_mem_model (
   input wire sys_clk, // core clock
   input wire mem_req, // read request
   input wire [15:0] mem_addr, // read address
   input wire [3:0] slow, // wait cycles before each answer
   output reg mem_ack, // one-cycle answer
   output reg [15:0] mem_rdata // read data
);
   reg [3:0] wait_r = 4'h0;
   initial
   begin
      mem_ack = 1'b0;
      mem_rdata = 16'h0000;
   end
   // contents follow the address so every word is predictable;
   // data flips between answers so a stale word is never mistaken for fresh
   always @(posedge sys_clk)
   begin
      if (mem_req && !mem_ack && wait_r >= slow)
      begin
         mem_ack <= 1'b1;
         mem_rdata <= mem_addr ^ 16'hc35a;
         wait_r <= 4'h0;
      end
      else
      begin
         mem_ack <= 1'b0;
         mem_rdata <= ~mem_rdata;
         wait_r <= mem_req ? wait_r + 4'h1 : 4'h0;
      end
   end
endmodule // oau_mem_model

/* File: sim/tb_top.sv */
// self-checking bench for the operand addressing unit
`timescale 1ns/1ps
module tb_top;
   reg sys_clk, rstn, clk_en, op_start, dst_mode, byte_op, res_valid;
   reg [3:0] src_num, dst_num, slow;
   reg [1:0] source_mode_field;
   reg [15:0] pc_in, res_data;
   wire mem_req, mem_ack, src_valid, dst_is_mem, busy;
   wire [15:0] mem_addr, mem_rdata, src_op, dst_op, dst_addr, pc_out;
   wire [3:0] flags_nzc;
   integer mismatches, cmp_count, i;
   reg [15:0] gr [0:15];
   // stack and status inputs are fixed; the register model mirrors them as numbers 1 and 2
   oau_top DUT (.sys_clk, .rstn, .clk_en, .op_start, .src_num, .source_mode_field, .dst_num,
      .dst_mode, .byte_op, .pc_in, .sp_in(16'h2400), .status_word_register(16'h00f3),
      .res_valid, .res_data, .mem_ack, .mem_rdata, .mem_req, .mem_addr, .src_valid, .src_op,
      .dst_op, .dst_is_mem, .dst_addr, .pc_out, .flags_nzc, .busy);
   oau_mem_model u_mem (.sys_clk, .mem_req, .mem_addr, .slow, .mem_ack, .mem_rdata);
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function [15:0] mv(input [15:0] a);
      mv = a ^ 16'hc35a;
   endfunction
   task check(input [15:0] seen, input [15:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (seen !== exp)
      begin
         mismatches = mismatches + 1;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task close_out;
   begin
      if (mismatches == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one full sequence; expectations come from the register model gr
   task op(input [3:0] sn, input [1:0] sm, input [3:0] dn, input dm, input by, input hold,
      input [15:0] res);
      reg [15:0] pc, es, ed, da, mk;
      reg [3:0] fl;
      integer n;
   begin
      mk = by ? 16'h00ff : 16'hffff;
      pc = pc_in;
      da = 16'h0000;
      if (sn == 4'h3 || (sn == 4'h2 && sm[1]))
         es = sn == 4'h2 ? (sm[0] ? 16'h0008 : 16'h0004) : sm == 2'h0 ? 16'h0000 :
            sm == 2'h1 ? 16'h0001 : sm == 2'h2 ? 16'h0002 : 16'hffff;
      else if (sm == 2'h0)
         es = gr[sn];
      else if (sm == 2'h1)
      begin
         es = mv((sn == 4'h2 ? 16'h0000 : sn == 4'h0 ? pc : gr[sn]) + mv(pc));
         pc = pc + 16'h0002;
      end
      else if (sm == 2'h2 || sn != 4'h0)
      begin
         es = mv(gr[sn]);
         if (sm[0])
            gr[sn] = gr[sn] + (by ? 16'h0001 : 16'h0002);
      end
      else
      begin
         es = mv(pc);
         pc = pc + 16'h0002;
      end
      ed = gr[dn];
      if (dm)
      begin
         da = gr[dn] + mv(pc);
         ed = mv(da);
         pc = pc + 16'h0002;
      end
      @(negedge sys_clk);
      {src_num, source_mode_field, dst_num, dst_mode} = {sn, sm, dn, dm};
      {byte_op, op_start} = {by, 1'b1};
      @(negedge sys_clk);
      op_start = 1'b0;
      n = 0;
      while (src_valid !== 1'b1 && n < 200)
      begin
         @(posedge sys_clk);
         #1;
         n = n + 1;
      end
      check(src_valid, 1'b1); // operands ready
      check(src_op, es & mk); // source
      check(dst_op, ed & mk); // destination
      check(dst_is_mem, dm); // destination kind
      check(pc_out, pc); // pc advance
      if (dm)
         check(dst_addr, da); // destination address
      @(negedge sys_clk);
      // a start while busy must be ignored, and a frozen clock holds the state
      if (hold)
      begin
         op_start = 1'b1;
         @(negedge sys_clk);
         {op_start, clk_en} = 2'b00;
         repeat (3) @(negedge sys_clk);
         check(busy, 1'b1); // still in sequence
         clk_en = 1'b1;
      end
      {res_valid, res_data} = {1'b1, res};
      @(negedge sys_clk);
      res_valid = 1'b0;
      @(negedge sys_clk);
      fl = by ? {res[7], res[7:0] == 8'h00, 2'b01} : {res[15], res == 16'h0000, 2'b00};
      check(busy, 1'b0); // result taken
      check(flags_nzc, fl); // flags
      if (!dm && dn >= 4'h4)
         gr[dn] = by ? {8'h00, res[7:0]} : res;
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // fill every general register by immediate, then read each back
   task t_load;
   begin
      for (i = 4; i < 16; i = i + 1)
         op(4'h0, 2'h3, i[3:0], 1'b0, 1'b0, 1'b0, {i[7:0], 8'h22} ^ 16'h1a00);
      for (i = 4; i < 16; i = i + 1)
         op(i[3:0], 2'h0, 4'h4, 1'b0, 1'b0, 1'b0, gr[4]);
   end
   endtask
   // byte results clear the high byte and set flags from the low byte
   task t_byte;
   begin
      op(4'h5, 2'h0, 4'h8, 1'b0, 1'b1, 1'b0, 16'hab8f);
      op(4'h8, 2'h0, 4'h9, 1'b0, 1'b0, 1'b0, 16'h0000);
      op(4'h5, 2'h0, 4'h9, 1'b0, 1'b1, 1'b1, 16'h1200);
   end
   endtask
   // memory modes mixed across source and destination, some with a slow memory
   task t_modes;
   begin
      op(4'h5, 2'h1, 4'h6, 1'b1, 1'b0, 1'b0, 16'h5555);
      op(4'h0, 2'h1, 4'h7, 1'b0, 1'b1, 1'b0, 16'h0077);
      op(4'h2, 2'h1, 4'h9, 1'b1, 1'b0, 1'b0, 16'h0000);
      slow = 4'h3;
      op(4'h6, 2'h2, 4'ha, 1'b0, 1'b1, 1'b0, 16'h0080);
      op(4'h4, 2'h3, 4'hb, 1'b0, 1'b1, 1'b0, 16'h0001);
      op(4'h4, 2'h3, 4'hc, 1'b1, 1'b0, 1'b1, 16'h0002);
      op(4'h0, 2'h3, 4'h7, 1'b1, 1'b0, 1'b0, 16'h0003);
      slow = 4'h0;
      op(4'h4, 2'h0, 4'hd, 1'b0, 1'b0, 1'b0, 16'h0004);
      // stack pointer and status word read in register mode
      op(4'h1, 2'h0, 4'h2, 1'b0, 1'b0, 1'b0, 16'h0000);
   end
   endtask
   // all six substituted constants, byte and word
   task t_consts;
   begin
      for (i = 0; i < 4; i = i + 1)
         op(4'h3, i[1:0], 4'he, 1'b0, i[0], 1'b0, 16'h00f0);
      op(4'h2, 2'h2, 4'he, 1'b0, 1'b0, 1'b0, 16'h8000);
      op(4'h2, 2'h3, 4'he, 1'b1, 1'b1, 1'b0, 16'h0000);
   end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {mismatches, cmp_count} = 0;
      {rstn, op_start, dst_mode, byte_op, res_valid, src_num, dst_num, slow} = 0;
      {source_mode_field, res_data, clk_en, pc_in} = {18'h0, 1'b1, 16'h4a00};
      for (i = 0; i < 16; i = i + 1)
         gr[i] = 16'h0000;
      gr[1] = 16'h2400;
      gr[2] = 16'h00f3;
      repeat (6) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (4) @(negedge sys_clk);
      t_load;
      t_byte;
      t_modes;
      t_consts;
      close_out;
   end
   // 42 sequences of under 40 cycles each; allow ten thousand cycles
   initial
   begin
      #50000;
      mismatches = mismatches + 1;
      close_out;
   end
endmodule // tb_top
